/* File: core/ifab_defs.svh */
`ifndef IFAB_DEFS_SVH
`define IFAB_DEFS_SVH

// register indices, byte address is four times the index
`define IFAB_IDX_CFG_A 6'h01
`define IFAB_IDX_CFG_B 6'h02
`define IFAB_IDX_STATUS 6'h04
`define IFAB_IDX_CLEAR 6'h05
`define IFAB_IDX_IRQ_EN 6'h06

// reset values
`define IFAB_RST_CFG_A 16'h000E
`define IFAB_RST_CFG_B 16'h7000
`define IFAB_RST_IRQ_EN 5'h00

// writable bits, everything else reads zero
`define IFAB_WMASK_CFG_A 16'h007E
`define IFAB_WMASK_CFG_B 16'hF000

// field positions in input_path_config_a
`define IFAB_A_CHAN_B_INVERT 6
`define IFAB_A_CHAN_C_INVERT 5
`define IFAB_A_CHAN_D_INVERT 4
`define IFAB_A_GAP_TWO_EN 3
`define IFAB_A_GAP_ONE_EN 2
`define IFAB_A_COLLISION_EN 1

// field positions in input_path_config_b
`define IFAB_B_WORD_WIDE 15
`define IFAB_B_CONV_CLK_OFF_EN 14
`define IFAB_B_DATA_CLK_OFF_EN 13
`define IFAB_B_COLLISION_OFF_EN 12

// field positions in the external alarm mask register
`define IFAB_M_COLLISION 13
`define IFAB_M_CONV_CLK 10
`define IFAB_M_DATA_CLK 9
`define IFAB_M_OUTPUT_GONE 8

// event status layout
`define IFAB_EVT_N 5
`define IFAB_EVT_GAP_TWO 0
`define IFAB_EVT_GAP_ONE 1
`define IFAB_EVT_COLLISION 2
`define IFAB_EVT_CONV_CLK 3
`define IFAB_EVT_DATA_CLK 4

`endif

/* File: core/ifab_pkg.sv */
package ifab_pkg;
   // register-sized containers
   typedef logic [15:0] ifab_half_t;
   typedef logic [31:0] ifab_word_t;
   typedef logic [4:0] ifab_evt_t;
endpackage

/* File: core/ifab_invert.sv */
`timescale 1ns/1ps
module ifab_invert #(
   parameter int DATA_W = 16
) (
   input wire logic ref_clk, // system clock
   input wire logic rstn, // synchronous reset, active low
   input wire logic invert, // complement the samples
   input wire logic [DATA_W-1:0] din, // incoming sample
   output logic [DATA_W-1:0] dout // registered sample
);
   logic [DATA_W-1:0] dout_ff;
   logic [DATA_W-1:0] nxt_dout;

   // complementing equals swapping the two senses of the pair
   always_comb begin
      nxt_dout = invert ? ~din : din;
   end

   // one stage so the output leaves a flip-flop
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         dout_ff <= '0;
      end else begin
         dout_ff <= nxt_dout;
      end
   end

   assign dout = dout_ff;
endmodule

/* File: core/ifab_top.sv */
`timescale 1ns/1ps
`include "ifab_defs.svh"

// Overview of operation
// RULE_01: set invert bit complements channel B, C or D samples; bits reset zero.
// RULE_02: pointers-two-apart alarm passes only while its enable is set; resets one.
// RULE_03: pointers-one-apart alarm passes only while bit 2 is set; resets one.
// RULE_04: pointer collision alarm passes only while bit 1 is set; resets one.
// RULE_05: second config bit 15 selects word-wide input when set, byte-wide clear.
// RULE_06: bit 14 lets conversion clock loss shut outputs; masks 10, 8 clear.
// RULE_07: bit 13 lets data clock loss shut outputs; masks 9, 8 clear.
// RULE_08: bit 12 lets FIFO collision shut outputs; masks 13, 8 clear. Code also requires first config bit 1 set.
// RULE_09: software writes zero to reserved bits and ignores their read value.
module ifab_top import ifab_pkg::*; #(
   parameter int DATA_W = 16
) (
   input wire logic ref_clk, // 40 MHz system clock
   input wire logic rstn, // synchronous reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, high is write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic fifo_gap_two, // fifo pointers two apart
   input wire logic fifo_gap_one, // fifo pointers one apart
   input wire logic fifo_collision, // fifo pointers collided
   input wire logic conv_clk_lost, // monitor: conversion clock gone
   input wire logic data_clk_lost, // monitor: data clock gone
   input wire logic [15:0] alarm_mask_reg, // external alarm mask value
   input wire logic [DATA_W-1:0] chan_b_in, // channel b samples
   input wire logic [DATA_W-1:0] chan_c_in, // channel c samples
   input wire logic [DATA_W-1:0] chan_d_in, // channel d samples
   output logic [DATA_W-1:0] chan_b_out, // channel b, maybe inverted
   output logic [DATA_W-1:0] chan_c_out, // channel c, maybe inverted
   output logic [DATA_W-1:0] chan_d_out, // channel d, maybe inverted
   output logic alarm_gap_two, // enabled two-apart alarm
   output logic alarm_gap_one, // enabled one-apart alarm
   output logic alarm_collision, // enabled collision alarm
   output logic word_wide_input, // input bus width select
   output logic outputs_off, // shut the outputs off
   output logic irq // level interrupt
);

   ////////////////////////////////////////////////////////////////////////
   // address decode

   // index match on the word address, low two bits ignored
   function automatic logic ifab_hit(input logic [7:0] addr,
                                     input logic [5:0] idx);
      ifab_hit = (addr[7:2] == idx);
   endfunction

   logic apb_setup;
   logic apb_done;
   logic wr_done;
   logic hit_a;
   logic hit_b;
   logic hit_status;
   logic hit_clear;
   logic hit_en;
   logic mapped;

   // a write lands only on the edge where the access completes
   assign apb_setup = psel & ~penable;
   assign apb_done = psel & penable & pready;
   assign wr_done = apb_done & pwrite;
   assign hit_a = ifab_hit(paddr, `IFAB_IDX_CFG_A);
   assign hit_b = ifab_hit(paddr, `IFAB_IDX_CFG_B);
   assign hit_status = ifab_hit(paddr, `IFAB_IDX_STATUS);
   assign hit_clear = ifab_hit(paddr, `IFAB_IDX_CLEAR);
   assign hit_en = ifab_hit(paddr, `IFAB_IDX_IRQ_EN);
   assign mapped = hit_a | hit_b | hit_status | hit_clear | hit_en;

   ////////////////////////////////////////////////////////////////////////
   // configuration registers

   ifab_half_t cfg_a_ff;
   ifab_half_t nxt_cfg_a;
   ifab_half_t cfg_b_ff;
   ifab_half_t nxt_cfg_b;
   ifab_evt_t irq_en_ff;
   ifab_evt_t nxt_irq_en;

   // reserved bits are never stored, so they always read zero
   always_comb begin
      nxt_cfg_a = cfg_a_ff;
      nxt_cfg_b = cfg_b_ff;
      nxt_irq_en = irq_en_ff;
      if (wr_done && hit_a) begin
         nxt_cfg_a = pwdata[15:0] & `IFAB_WMASK_CFG_A; // RULE_09
      end
      if (wr_done && hit_b) begin
         nxt_cfg_b = pwdata[15:0] & `IFAB_WMASK_CFG_B; // RULE_09
      end
      if (wr_done && hit_en) begin
         nxt_irq_en = pwdata[`IFAB_EVT_N-1:0];
      end
   end

   // defaults: alarms and shutdown paths enabled, byte-wide bus
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cfg_a_ff <= `IFAB_RST_CFG_A; // RULE_01
         cfg_b_ff <= `IFAB_RST_CFG_B; // RULE_05
         irq_en_ff <= `IFAB_RST_IRQ_EN;
      end else begin
         cfg_a_ff <= nxt_cfg_a;
         cfg_b_ff <= nxt_cfg_b;
         irq_en_ff <= nxt_irq_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alarm gating and output shutdown

   logic gap_two_g;
   logic gap_one_g;
   logic collision_g;
   logic nxt_off;
   logic alarm_gap_two_ff;
   logic alarm_gap_one_ff;
   logic alarm_collision_ff;
   logic outputs_off_ff;
   logic out_gone_open;

   assign gap_two_g = fifo_gap_two & cfg_a_ff[`IFAB_A_GAP_TWO_EN]; // RULE_02
   assign gap_one_g = fifo_gap_one & cfg_a_ff[`IFAB_A_GAP_ONE_EN]; // RULE_03
   assign collision_g = fifo_collision
                      & cfg_a_ff[`IFAB_A_COLLISION_EN]; // RULE_04
   assign out_gone_open = ~alarm_mask_reg[`IFAB_M_OUTPUT_GONE];

   // a masked alarm never reaches the shutdown, as software was warned
   always_comb begin
      nxt_off = 1'b0;
      if (cfg_b_ff[`IFAB_B_CONV_CLK_OFF_EN] && conv_clk_lost &&
          !alarm_mask_reg[`IFAB_M_CONV_CLK] && out_gone_open) begin
         nxt_off = 1'b1; // RULE_06
      end
      if (cfg_b_ff[`IFAB_B_DATA_CLK_OFF_EN] && data_clk_lost &&
          !alarm_mask_reg[`IFAB_M_DATA_CLK] && out_gone_open) begin
         nxt_off = 1'b1; // RULE_07
      end
      if (cfg_b_ff[`IFAB_B_COLLISION_OFF_EN] && collision_g &&
          !alarm_mask_reg[`IFAB_M_COLLISION] && out_gone_open) begin
         nxt_off = 1'b1; // RULE_08
      end
   end

   // shutdown follows the level, the outputs return once it clears
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         alarm_gap_two_ff <= 1'b0;
         alarm_gap_one_ff <= 1'b0;
         alarm_collision_ff <= 1'b0;
         outputs_off_ff <= 1'b0;
      end else begin
         alarm_gap_two_ff <= gap_two_g;
         alarm_gap_one_ff <= gap_one_g;
         alarm_collision_ff <= collision_g;
         outputs_off_ff <= nxt_off;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event status and interrupt

   ifab_evt_t evt;
   ifab_evt_t clr;
   ifab_evt_t status_ff;
   ifab_evt_t nxt_status;
   logic irq_ff;
   logic nxt_irq;

   assign evt = {data_clk_lost, conv_clk_lost, collision_g,
                 gap_one_g, gap_two_g};
   assign clr = (wr_done && hit_clear) ? pwdata[`IFAB_EVT_N-1:0] : '0;

   // set beats clear, so an event in the clearing cycle is kept
   always_comb begin
      nxt_status = (status_ff & ~clr) | evt;
      nxt_irq = |(nxt_status & nxt_irq_en);
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         status_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         irq_ff <= nxt_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb answer

   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pready_ff;
   logic nxt_pready;
   logic pslverr_ff;
   logic nxt_pslverr;
   ifab_word_t rd_mux;

   // clear register is write-only and reads zero
   always_comb begin
      rd_mux = '0;
      if (hit_a) begin
         rd_mux = {16'h0000, cfg_a_ff};
      end else if (hit_b) begin
         rd_mux = {16'h0000, cfg_b_ff};
      end else if (hit_status) begin
         rd_mux = {27'h0, status_ff};
      end else if (hit_en) begin
         rd_mux = {27'h0, irq_en_ff};
      end
   end

   // data is caught in setup so ready can leave a flip-flop;
   // the access phase still completes in its first cycle, with no wait state
   always_comb begin
      nxt_pready = apb_setup;
      nxt_prdata = prdata_ff;
      nxt_pslverr = pslverr_ff;
      if (apb_setup) begin
         nxt_prdata = pwrite ? 32'h00000000 : rd_mux;
         nxt_pslverr = ~mapped;
      end else if (apb_done) begin
         nxt_prdata = 32'h00000000;
         nxt_pslverr = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-channel sample complement

   ifab_invert #(.DATA_W(DATA_W)) u_inv_b (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .invert(cfg_a_ff[`IFAB_A_CHAN_B_INVERT]), // RULE_01
      .din(chan_b_in),
      .dout(chan_b_out)
   );

   ifab_invert #(.DATA_W(DATA_W)) u_inv_c (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .invert(cfg_a_ff[`IFAB_A_CHAN_C_INVERT]), // RULE_01
      .din(chan_c_in),
      .dout(chan_c_out)
   );

   ifab_invert #(.DATA_W(DATA_W)) u_inv_d (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .invert(cfg_a_ff[`IFAB_A_CHAN_D_INVERT]), // RULE_01
      .din(chan_d_in),
      .dout(chan_d_out)
   );

   // output drive, all straight from flip-flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign alarm_gap_two = alarm_gap_two_ff;
   assign alarm_gap_one = alarm_gap_one_ff;
   assign alarm_collision = alarm_collision_ff;
   assign word_wide_input = cfg_b_ff[`IFAB_B_WORD_WIDE];
   assign outputs_off = outputs_off_ff;
   assign irq = irq_ff;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   sequence wr_cfg_b_s;
      psel && penable && pready && pwrite && hit_b;
   endsequence
   sequence wr_cfg_a_s;
      psel && penable && pready && pwrite && hit_a;
   endsequence
   sequence conv_lost_s;
      cfg_b_ff[14] && conv_clk_lost && !alarm_mask_reg[10] &&
      !alarm_mask_reg[8];
   endsequence

   invert_b_a: assert property ( // RULE_01
      ##1 chan_b_out == ($past(cfg_a_ff[6]) ? ~$past(chan_b_in)
                                            : $past(chan_b_in)))
      else $error("channel b complement wrong");
   gap_two_a: assert property ( // RULE_02
      wr_cfg_a_s ##1 (!cfg_a_ff[3] && fifo_gap_two)
      |=> !alarm_gap_two)
      else $error("two-apart alarm passed while disabled");
   gap_one_a: assert property ( // RULE_03
      (fifo_gap_one && cfg_a_ff[2]) |=> alarm_gap_one && status_ff[1])
      else $error("one-apart alarm not passed");
   collision_gate_a: assert property ( // RULE_04
      alarm_collision |-> $past(fifo_collision) && $past(cfg_a_ff[1]))
      else $error("collision alarm without enabled cause");
   word_wide_a: assert property ( // RULE_05
      wr_cfg_b_s |=> word_wide_input == $past(pwdata[15]))
      else $error("word-wide select not updated");
   conv_off_a: assert property ( // RULE_06
      conv_lost_s |=> outputs_off)
      else $error("conversion clock loss did not shut outputs");
   data_off_a: assert property ( // RULE_07
      (cfg_b_ff[13] && data_clk_lost && !alarm_mask_reg[9] &&
       !alarm_mask_reg[8]) |=> outputs_off [*1] ##0 status_ff[4])
      else $error("data clock loss did not shut outputs");
   coll_off_a: assert property ( // RULE_08
      outputs_off && !$past(conv_clk_lost) && !$past(data_clk_lost)
      |-> $past(cfg_b_ff[12]) && $past(collision_g) &&
          !$past(alarm_mask_reg[13]) && !$past(alarm_mask_reg[8]))
      else $error("outputs shut without enabled cause");
   reserved_bits_a: assert property ( // RULE_09
      wr_cfg_a_s |=> !cfg_a_ff[0] && cfg_b_ff[11] == 1'b0)
      else $error("reserved bit stored");
   ready_one_a: assert property (
      (psel && !penable) |=> pready ##1 !pready)
      else $error("apb ready not a single cycle");
endmodule

/* File: tb/input_fifo_alarm_config_bank_tb.sv */
`timescale 1ns/1ps
`include "ifab_defs.svh"
module input_fifo_alarm_config_bank_tb import ifab_pkg::*;;
   localparam logic [7:0] A_CFG_A = {`IFAB_IDX_CFG_A, 2'b00};
   localparam logic [7:0] A_CFG_B = {`IFAB_IDX_CFG_B, 2'b00};
   localparam logic [7:0] A_STAT = {`IFAB_IDX_STATUS, 2'b00};
   localparam logic [7:0] A_CLR = {`IFAB_IDX_CLEAR, 2'b00};
   localparam logic [7:0] A_IEN = {`IFAB_IDX_IRQ_EN, 2'b00};
   localparam logic [7:0] A_NONE = 8'h0C;
   logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic fifo_gap_two, fifo_gap_one, fifo_collision;
   logic conv_clk_lost, data_clk_lost;
   logic [15:0] alarm_mask_reg;
   logic [15:0] chan_b_in, chan_c_in, chan_d_in;
   logic [15:0] chan_b_out, chan_c_out, chan_d_out;
   logic alarm_gap_two, alarm_gap_one, alarm_collision;
   logic word_wide_input, outputs_off, irq;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;

   ifab_top #(.DATA_W(16)) u_dut (
      .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fifo_gap_two(fifo_gap_two),
      .fifo_gap_one(fifo_gap_one), .fifo_collision(fifo_collision),
      .conv_clk_lost(conv_clk_lost), .data_clk_lost(data_clk_lost),
      .alarm_mask_reg(alarm_mask_reg), .chan_b_in(chan_b_in),
      .chan_c_in(chan_c_in), .chan_d_in(chan_d_in),
      .chan_b_out(chan_b_out), .chan_c_out(chan_c_out),
      .chan_d_out(chan_d_out), .alarm_gap_two(alarm_gap_two),
      .alarm_gap_one(alarm_gap_one), .alarm_collision(alarm_collision),
      .word_wide_input(word_wide_input), .outputs_off(outputs_off),
      .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   initial ref_clk = 1'b0;
   always #12.5 ref_clk = ~ref_clk;

   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         $display("unexpected at %0t: run did not finish", $time);
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reporting
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got,
                  exp);
      end
   endtask

   // let the edge that samples the input pass, then read at the next
   task automatic settle();
      repeat (2) @(posedge ref_clk);
   endtask

   ////////////////////////////////////////////////////////////////////
   // apb master, entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      // no fixed latency assumed, only the bench timeout cuts the wait
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n, 32'h1, "apb access cycles");
      // one idle edge, so a following call never re-drives psel at once
      @(posedge ref_clk);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
      chk({31'h0, err}, 32'h0, "write error flag");
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input string msg);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, exp, msg);
      chk({31'h0, err}, 32'h0, "read error flag");
   endtask

   ////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      rd_chk(A_CFG_A, 32'h0000_000E, "cfg_a reset");
      rd_chk(A_CFG_B, 32'h0000_7000, "cfg_b reset");
      rd_chk(A_STAT, 32'h0, "status reset");
      rd_chk(A_IEN, 32'h0, "irq enable reset");
      chk({31'h0, word_wide_input}, 32'h0, "byte wide at reset");
      chk({31'h0, outputs_off}, 32'h0, "outputs on at reset");
   endtask

   task automatic t_invert();
      logic [15:0] m;
      chan_b_in <= 16'h1234;
      chan_c_in <= 16'hA5C3;
      chan_d_in <= 16'h00FF;
      for (int i = 0; i < 4; i++) begin
         // i == 3 sets all three invert bits together
         m = (i == 3) ? 16'h0070 : (16'h0040 >> i);
         wr_reg(A_CFG_A, {16'h0, m | 16'h000E});
         settle();
         chk({16'h0, chan_b_out}, {16'h0, m[6] ? 16'hEDCB : 16'h1234},
             "chan b");
         chk({16'h0, chan_c_out}, {16'h0, m[5] ? 16'h5A3C : 16'hA5C3},
             "chan c");
         chk({16'h0, chan_d_out}, {16'h0, m[4] ? 16'hFF00 : 16'h00FF},
             "chan d");
      end
      rd_chk(A_CFG_A, 32'h0000_007E, "cfg_a readback");
      wr_reg(A_CFG_A, 32'h0000_000E);
   endtask

   task automatic t_alarm();
      logic [3:0] e;
      fifo_gap_two <= 1'b1;
      fifo_gap_one <= 1'b1;
      fifo_collision <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         e = (i == 0) ? 4'hE : (i == 4) ? 4'h0 : (4'h8 >> (i - 1));
         wr_reg(A_CFG_A, {28'h0, e});
         settle();
         chk({31'h0, alarm_gap_two}, {31'h0, e[3]}, "gap two");
         chk({31'h0, alarm_gap_one}, {31'h0, e[2]}, "gap one");
         chk({31'h0, alarm_collision}, {31'h0, e[1]}, "collide");
      end
      fifo_gap_two <= 1'b0;
      fifo_gap_one <= 1'b0;
      fifo_collision <= 1'b0;
      wr_reg(A_CFG_A, 32'h0000_000E);
   endtask

   task automatic t_width();
      wr_reg(A_CFG_B, 32'h0000_F000);
      settle();
      chk({31'h0, word_wide_input}, 32'h1, "word wide");
      rd_chk(A_CFG_B, 32'h0000_F000, "cfg_b readback");
      wr_reg(A_CFG_B, 32'h0000_7000);
      settle();
      chk({31'h0, word_wide_input}, 32'h0, "byte wide");
   endtask

   task automatic cause(input int c, input logic v);
      case (c)
         0: conv_clk_lost <= v;
         1: data_clk_lost <= v;
         default: fifo_collision <= v;
      endcase
   endtask

   // each cause alone, gated by its enable and by both masks
   task automatic t_shutdown();
      int mb;
      for (int c = 0; c < 3; c++) begin
         mb = (c == 0) ? 10 : (c == 1) ? 9 : 13;
         alarm_mask_reg <= 16'h0;
         cause(c, 1'b1);
         settle();
         chk({31'h0, outputs_off}, 32'h1, "shut");
         wr_reg(A_CFG_B, 32'h0000_7000 & ~(32'h1 << (14 - c)));
         settle();
         chk({31'h0, outputs_off}, 32'h0, "en off");
         wr_reg(A_CFG_B, 32'h0000_7000);
         alarm_mask_reg <= 16'h1 << mb;
         settle();
         chk({31'h0, outputs_off}, 32'h0, "masked");
         alarm_mask_reg <= 16'h0100;
         settle();
         chk({31'h0, outputs_off}, 32'h0, "gone mk");
         alarm_mask_reg <= 16'h0;
         cause(c, 1'b0);
         settle();
         chk({31'h0, outputs_off}, 32'h0, "level");
      end
      wr_reg(A_CLR, 32'h0000_001F);
   endtask

   task automatic t_irq();
      logic [31:0] rd;
      logic err;
      rd_chk(A_STAT, 32'h0, "status cleared");
      fifo_gap_one <= 1'b1;
      data_clk_lost <= 1'b1;
      settle();
      rd_chk(A_STAT, 32'h0000_0012, "status set");
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr_reg(A_IEN, 32'h0000_0010);
      settle();
      chk({31'h0, irq}, 32'h1, "irq raised");
      fifo_gap_one <= 1'b0;
      data_clk_lost <= 1'b0;
      wr_reg(A_CLR, 32'h0000_0010);
      settle();
      chk({31'h0, irq}, 32'h0, "irq cleared");
      // status is read only, a write must leave it alone
      wr_reg(A_STAT, 32'h0000_FFFF);
      rd_chk(A_STAT, 32'h0000_0002, "status sticky");
      rd_chk(A_IEN, 32'h0000_0010, "irq enable readback");
      wr_reg(A_IEN, 32'h0000_0002);
      settle();
      chk({31'h0, irq}, 32'h1, "irq other bit");
      wr_reg(A_CLR, 32'h0000_0002);
      settle();
      chk({31'h0, irq}, 32'h0, "irq other cleared");
      apb(1'b0, A_NONE, 32'h0, rd, err);
      chk(rd, 32'h0, "unmapped read data");
      chk({31'h0, err}, 32'h1, "unmapped read error");
      apb(1'b1, A_NONE, 32'hFFFF_FFFF, rd, err);
      chk({31'h0, err}, 32'h1, "unmapped write error");
   endtask

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fifo_gap_two = 1'b0;
      fifo_gap_one = 1'b0;
      fifo_collision = 1'b0;
      conv_clk_lost = 1'b0;
      data_clk_lost = 1'b0;
      alarm_mask_reg = 16'h0;
      chan_b_in = 16'h0;
      chan_c_in = 16'h0;
      chan_d_in = 16'h0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      t_reset();
      t_invert();
      t_alarm();
      t_width();
      t_shutdown();
      t_irq();
      test_done();
   end
endmodule
